// File: bpse_cfg.svh
// constants of the beam pattern switch evaluator
`ifndef BPSE_CFG_SVH
`define BPSE_CFG_SVH

`define BPSE_BEAMS          32
`define BPSE_OUTS           2
`define BPSE_CFG0_OFS       8'h00
`define BPSE_CFG1_OFS       8'h04
`define BPSE_THR_OFS        8'h08
`define BPSE_STAT_OFS       8'h0c
`define BPSE_CFG_RST        32'h0000_0000
`define BPSE_THR_RST        32'h0000_0000
// output configuration word
`define BPSE_FN_LSB         0
`define BPSE_REL_LSB        4
`define BPSE_CONTIG_BIT     6
`define BPSE_INNER_BIT      7
`define BPSE_INVERT_BIT     8
`define BPSE_N_LSB          16
`define BPSE_EN_CONTAM_BIT  24
`define BPSE_EN_SHORT_BIT   25
`define BPSE_EN_TEACH_BIT   26
`define BPSE_EN_HW_BIT      27
`define BPSE_EN_TQ_BIT      28
`define BPSE_EN_PQ_BIT      29
// threshold word
`define BPSE_TQ_LSB         0
`define BPSE_PQ_LSB         8
// status word
`define BPSE_ST_OUT_LSB     0
`define BPSE_ST_BLK_LSB     8
`define BPSE_ST_MADE_LSB    16
`define BPSE_ST_OBJ_BIT     24
`define BPSE_ST_HOLE_BIT    25

`endif

// File: bpse_pkg.sv
// types of the beam pattern switch evaluator
package bpse_pkg;

  typedef enum logic [3:0] {
    BPSE_FN_OFF      = 4'h0,
    BPSE_FN_OBJ_SIZE = 4'h1,
    BPSE_FN_HOLE_SIZE= 4'h2,
    BPSE_FN_DIM      = 4'h3,
    BPSE_FN_OBJ_POS  = 4'h4,
    BPSE_FN_HOLE_POS = 4'h5,
    BPSE_FN_DIAG     = 4'h6
  } bpse_fn_e;

  typedef enum logic [1:0] {
    BPSE_REL_GE = 2'h0,
    BPSE_REL_LE = 2'h1,
    BPSE_REL_EQ = 2'h2
  } bpse_rel_e;

  typedef logic [5:0] bpse_cnt_t;

  typedef struct packed {
    bpse_cnt_t  len;
    logic [4:0] start;
  } bpse_run_s;

endpackage

// File: bpse_evaluator.sv
// beam pattern switch evaluator: per-scan measuring and diagnostic switching outputs
`timescale 1ns/1ps
`include "bpse_cfg.svh"

module bpse_evaluator
  import bpse_pkg::*;
(
  // clock, reset, enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // beam receiver side
  input  wire logic [`BPSE_BEAMS-1:0]  beam_blocked,
  input  wire logic                    scan_done,
  input  wire logic                    diag_contam,
  input  wire logic                    diag_short,
  input  wire logic                    diag_teach_err,
  input  wire logic                    diag_hw_err,
  input  wire logic [6:0]              teach_quality,
  input  wire logic [6:0]              process_quality,
  // machine control side
  output logic      [`BPSE_OUTS-1:0]   switching_output_n
);

  typedef struct packed {
    logic [`BPSE_OUTS-1:0][31:0] cfg;
    logic [31:0]                 thr;
    logic [`BPSE_BEAMS-1:0]      vec;
    logic                        pending;
    logic [`BPSE_OUTS-1:0]       outs;
    bpse_cnt_t                   blk_cnt;
    bpse_cnt_t                   made_cnt;
    logic                        obj_ok;
    logic                        hole_ok;
    logic [31:0]                 rdata;
    logic                        rd_ok;
  } bpse_state_s;

  bpse_state_s st_reg;
  bpse_state_s st_next;

  function automatic bpse_cnt_t popcount(input logic [`BPSE_BEAMS-1:0] v, input logic pol);
    bpse_cnt_t c;
    c = '0;
    for (int i = 0; i < `BPSE_BEAMS; i++)
    begin
      if (v[i] == pol)
        c = c + 6'h01;
    end
    return c;
  endfunction

  // largest run of beams equal to pol; ties keep the lowest run;
  // enclosed excludes runs touching either end of the grid
  function automatic bpse_run_s longest_run(input logic [`BPSE_BEAMS-1:0] v,
                                            input logic pol, input logic enclosed);
    bpse_run_s  best;
    bpse_cnt_t  cur;
    logic [4:0] s;
    best = '0;
    cur  = '0;
    s    = '0;
    for (int i = 0; i < `BPSE_BEAMS; i++)
    begin
      if (v[i] == pol)
      begin
        if (cur == 6'h00)
          s = 5'(i);
        cur = cur + 6'h01;
      end
      else
      begin
        if (cur != 6'h00 && (!enclosed || s != 5'h00) && cur > best.len)
        begin
          best.len   = cur;
          best.start = s;
        end
        cur = '0;
      end
    end
    if (cur != 6'h00 && !enclosed && cur > best.len)
    begin
      best.len   = cur;
      best.start = s;
    end
    return best;
  endfunction

  // centre beam, numbered from 1; lower middle for an even run
  function automatic bpse_cnt_t centre(input bpse_run_s r);
    return 6'(r.start) + ((r.len - 6'h01) >> 1) + 6'h01;
  endfunction

  function automatic logic relate(input bpse_cnt_t val, input bpse_cnt_t n,
                                  input logic [1:0] rel);
    logic r;
    r = 1'b0;
    case (rel)
      BPSE_REL_GE: r = (val >= n);
      BPSE_REL_LE: r = (val <= n);
      BPSE_REL_EQ: r = (val == n);
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  // analysis of the latched vector and of the quality inputs, shared by every output
  bpse_run_s obj_run;
  bpse_run_s hole_run;
  bpse_run_s inner_run;
  bpse_cnt_t blk_all;
  bpse_cnt_t made_all;
  logic      tq_low;
  logic      pq_low;

  always_comb
  begin
    obj_run   = longest_run(st_reg.vec, 1'b1, 1'b0);
    hole_run  = longest_run(st_reg.vec, 1'b0, 1'b0);
    inner_run = longest_run(st_reg.vec, 1'b0, 1'b1);
    blk_all   = popcount(st_reg.vec, 1'b1);
    made_all  = popcount(st_reg.vec, 1'b0);
    tq_low    = teach_quality < st_reg.thr[`BPSE_TQ_LSB+:7];
    pq_low    = process_quality < st_reg.thr[`BPSE_PQ_LSB+:7];
  end

  // per-output function evaluation
  logic [`BPSE_OUTS-1:0] eval_out;

  always_comb
  begin
    logic [31:0] c;
    logic [1:0]  rel;
    bpse_cnt_t   n;
    logic        hit;
    logic        valid;
    c     = '0;
    rel   = '0;
    n     = '0;
    hit   = 1'b0;
    valid = 1'b1;
    for (int k = 0; k < `BPSE_OUTS; k++)
    begin
      c     = st_reg.cfg[k];
      rel   = c[`BPSE_REL_LSB+:2];
      n     = c[`BPSE_N_LSB+:6];
      hit   = 1'b0;
      valid = 1'b1;
      case (c[`BPSE_FN_LSB+:4])
        BPSE_FN_OBJ_SIZE:
          hit = relate(c[`BPSE_CONTIG_BIT] ? obj_run.len : blk_all, n, rel);
        BPSE_FN_HOLE_SIZE:
          hit = relate(c[`BPSE_CONTIG_BIT] ? hole_run.len : made_all, n, rel);
        BPSE_FN_DIM:
        begin
          // outer: largest object; inner: largest gap bounded by blocked beams
          valid = c[`BPSE_INNER_BIT] ? (inner_run.len != 6'h00)
                                     : (obj_run.len != 6'h00);
          hit   = relate(c[`BPSE_INNER_BIT] ? inner_run.len : obj_run.len, n, rel);
        end
        BPSE_FN_OBJ_POS:
        begin
          valid = (obj_run.len != 6'h00);
          hit   = relate(centre(obj_run), n, rel);
        end
        BPSE_FN_HOLE_POS:
        begin
          valid = (hole_run.len != 6'h00);
          hit   = relate(centre(hole_run), n, rel);
        end
        BPSE_FN_DIAG:
          hit = (c[`BPSE_EN_CONTAM_BIT] && diag_contam)
              || (c[`BPSE_EN_SHORT_BIT] && diag_short)
              || (c[`BPSE_EN_TEACH_BIT] && diag_teach_err)
              || (c[`BPSE_EN_HW_BIT] && diag_hw_err)
              || (c[`BPSE_EN_TQ_BIT] && tq_low)
              || (c[`BPSE_EN_PQ_BIT] && pq_low);
        default:
          hit = 1'b0;
      endcase
      // an invalid measurement stays off even when inverted
      eval_out[k] = valid && (hit ^ c[`BPSE_INVERT_BIT]);
    end
  end

  // apb decode
  logic acc;
  logic mapped;

  always_comb
  begin
    mapped  = (paddr == `BPSE_CFG0_OFS) || (paddr == `BPSE_CFG1_OFS)
           || (paddr == `BPSE_THR_OFS) || (paddr == `BPSE_STAT_OFS);
    acc     = psel && penable && clk_en;
    // a setup edge lost to a low clock enable costs one wait state to fetch read data
    pready  = acc && (pwrite || st_reg.rd_ok);
    pslverr = pready && (!mapped || (pwrite && paddr == `BPSE_STAT_OFS));
    prdata  = st_reg.rdata;
  end

  always_comb
  begin
    st_next = st_reg;
    // read data is fetched in the setup cycle so prdata leaves a flip-flop
    if (psel && !pwrite && !(penable && st_reg.rd_ok))
    begin
      st_next.rd_ok = 1'b1;
      case (paddr)
        `BPSE_CFG0_OFS: st_next.rdata = st_reg.cfg[0];
        `BPSE_CFG1_OFS: st_next.rdata = st_reg.cfg[1];
        `BPSE_THR_OFS:  st_next.rdata = {17'h0_0000, st_reg.thr[`BPSE_PQ_LSB+:7],
                                         1'b0, st_reg.thr[`BPSE_TQ_LSB+:7]};
        `BPSE_STAT_OFS: st_next.rdata = {6'h00, st_reg.hole_ok, st_reg.obj_ok,
                                         2'h0, st_reg.made_cnt, 2'h0, st_reg.blk_cnt,
                                         6'h00, st_reg.outs};
        default:        st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (pready && !pwrite)
      st_next.rd_ok = 1'b0;
    if (acc && pwrite)
    begin
      case (paddr)
        `BPSE_CFG0_OFS: st_next.cfg[0] = pwdata;
        `BPSE_CFG1_OFS: st_next.cfg[1] = pwdata;
        `BPSE_THR_OFS:  st_next.thr    = pwdata & 32'h0000_7f7f;
        default:        st_next.thr    = st_reg.thr;
      endcase
    end
    // latch the whole pattern at scan end, evaluate on the next edge
    st_next.pending = scan_done;
    if (scan_done)
      st_next.vec = beam_blocked;
    if (st_reg.pending)
    begin
      st_next.outs     = eval_out;
      st_next.blk_cnt  = blk_all;
      st_next.made_cnt = made_all;
      st_next.obj_ok   = (obj_run.len != 6'h00);
      st_next.hole_ok  = (hole_run.len != 6'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg          <= '0;
      st_reg.cfg[0]   <= `BPSE_CFG_RST;
      st_reg.cfg[1]   <= `BPSE_CFG_RST;
      st_reg.thr      <= `BPSE_THR_RST;
    end
    else if (clk_en)
      st_reg <= st_next;
  end

  assign switching_output_n = st_reg.outs;

  // checks on output 0, on the scan timing and on the apb handshake
  logic [31:0] c0;
  logic        eval0;
  logic        inv0;
  bpse_cnt_t   n0;
  logic [3:0]  fn0;
  logic [1:0]  rel0;

  assign c0    = st_reg.cfg[0];
  assign inv0  = c0[`BPSE_INVERT_BIT];
  assign n0    = c0[`BPSE_N_LSB+:6];
  assign fn0   = c0[`BPSE_FN_LSB+:4];
  assign rel0  = c0[`BPSE_REL_LSB+:2];
  assign eval0 = st_reg.pending && clk_en;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_scan_end;
    scan_done && clk_en;
  endsequence

  sequence s_eval_step;
    ##1 st_reg.pending;
  endsequence

  a_scan_eval: assert property (s_scan_end |-> s_eval_step)
    else $error("scan end not followed by evaluation");

  a_out_hold: assert property (!eval0 |=> $stable(switching_output_n))
    else $error("output changed outside evaluation");

  a_obj_ge: assert property (eval0 && fn0 == BPSE_FN_OBJ_SIZE && rel0 == BPSE_REL_GE
      && !c0[`BPSE_CONTIG_BIT] |=> switching_output_n[0] == (($past(blk_all) >= $past(n0))
      ^ $past(inv0)))
    else $error("object size at-least output wrong");

  a_obj_le: assert property (eval0 && fn0 == BPSE_FN_OBJ_SIZE && rel0 == BPSE_REL_LE
      && c0[`BPSE_CONTIG_BIT] && !inv0 |=> switching_output_n[0] == ($past(obj_run.len)
      <= $past(n0)))
    else $error("object size at-most output wrong");

  a_hole_eq: assert property (eval0 && fn0 == BPSE_FN_HOLE_SIZE && rel0 == BPSE_REL_EQ
      && !inv0 |=> switching_output_n[0] == ($past(c0[`BPSE_CONTIG_BIT])
      ? ($past(hole_run.len) == $past(n0)) : ($past(made_all) == $past(n0))))
    else $error("hole size equality output wrong");

  a_pos_none: assert property (eval0 && (fn0 == BPSE_FN_OBJ_POS) && st_reg.vec == '0
      |=> !switching_output_n[0])
    else $error("position output on with no object");

  a_inv_flip: assert property (eval0 && fn0 == BPSE_FN_DIAG
      |=> switching_output_n[0] == ($past(inv0) ^ ($past(c0[`BPSE_EN_HW_BIT])
      && $past(diag_hw_err) || $past(c0[`BPSE_EN_CONTAM_BIT]) && $past(diag_contam)
      || $past(c0[`BPSE_EN_SHORT_BIT]) && $past(diag_short)
      || $past(c0[`BPSE_EN_TEACH_BIT]) && $past(diag_teach_err)
      || $past(c0[`BPSE_EN_TQ_BIT]) && $past(tq_low)
      || $past(c0[`BPSE_EN_PQ_BIT]) && $past(pq_low))))
    else $error("diagnostic output or inversion wrong");

  a_tq_thr: assert property (eval0 && fn0 == BPSE_FN_DIAG && !inv0
      && c0[`BPSE_EN_TQ_BIT] && teach_quality < st_reg.thr[`BPSE_TQ_LSB+:7]
      |=> switching_output_n[0])
    else $error("teach quality threshold not signalled");

  a_diag_off: assert property (eval0 && fn0 == BPSE_FN_DIAG && !inv0
      && c0[29:24] == 6'h00 |=> !switching_output_n[0])
    else $error("diagnostic output on with all enables off");

  a_apb_ready: assert property (psel && !penable && clk_en ##1 psel && penable && clk_en
      |-> pready)
    else $error("apb access not answered in first access cycle");

  a_rd_fetch: assert property (psel && !penable && !pwrite && clk_en |=> st_reg.rd_ok)
    else $error("read data not fetched in setup cycle");

  a_diag_short: assert property (eval0 && fn0 == BPSE_FN_DIAG && !inv0
      && c0[`BPSE_EN_SHORT_BIT] && diag_short |=> switching_output_n[0])
    else $error("short circuit not signalled");

endmodule // bpse_evaluator

// File: bpse_ctrl_model.sv
// behavioural machine control that samples the switching outputs
`timescale 1ns/1ps

module bpse_ctrl_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // switching outputs as seen by the control
  input  wire logic [1:0] switching_output_n,
  output logic      [1:0] level,
  output logic      [7:0] edges
);
  // rising edges are counted so that a spurious re-evaluation shows up
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level <= 2'h0;
      edges <= 8'h00;
    end
    else
    begin
      level <= switching_output_n;
      if (|(switching_output_n & ~level))
        edges <= edges + 8'h01;
    end
  end
endmodule // bpse_ctrl_model

// File: test_beam_pattern_switch_evaluator.sv
// self-checking testbench of the beam pattern switch evaluator
`timescale 1ns/1ps
`include "bpse_cfg.svh"

module test_beam_pattern_switch_evaluator
  import bpse_pkg::*;
;
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] beams;
    logic [5:0]  d;
    logic        e;
  } bpse_row_s;

  localparam logic [31:0] P1 = 32'h0000_0f0f;
  localparam logic [31:0] P2 = 32'h0000_0f83;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] beam_blocked = 32'h0;
  logic        scan_done = 1'b0;
  logic [3:0]  diag = 4'h0;
  logic [6:0]  teach_quality = 7'h64;
  logic [6:0]  process_quality = 7'h64;
  logic [1:0]  switching_output_n;
  logic [1:0]  ctrl_level;
  logic [7:0]  ctrl_edges;
  logic [7:0]  edges_was;
  logic [31:0] rd;
  logic        rerr;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  bpse_row_s   rows[$];

  always #2.5 pclk = ~pclk;

  bpse_evaluator u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .beam_blocked(beam_blocked), .scan_done(scan_done),
    .diag_contam(diag[0]), .diag_short(diag[1]), .diag_teach_err(diag[2]),
    .diag_hw_err(diag[3]), .teach_quality(teach_quality), .process_quality(process_quality),
    .switching_output_n(switching_output_n)
  );

  bpse_ctrl_model u_ctrl (
    .pclk(pclk), .presetn(presetn), .switching_output_n(switching_output_n),
    .level(ctrl_level), .edges(ctrl_edges)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // d: [3:0] fault flags, [4] teach quality below 50, [5] process quality below 60
  task automatic scan(input logic [31:0] b, input logic [5:0] d);
    @(posedge pclk);
    beam_blocked <= b;
    scan_done <= 1'b1;
    diag <= d[3:0];
    teach_quality <= d[4] ? 7'h31 : 7'h32;
    process_quality <= d[5] ? 7'h3b : 7'h3c;
    @(posedge pclk);
    scan_done <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  function automatic logic [31:0] cf(input int fn, input int rel, input int fl, input int n,
                                     input int en = 0);
    return 32'(fn) | (32'(rel) << 4) | (32'(fl) << 6) | (32'(n) << 16) | (32'(en) << 24);
  endfunction

  task automatic add(input logic [31:0] c, input logic [31:0] b, input logic [5:0] d,
                     input logic e);
    rows.push_back('{c, b, d, e});
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(switching_output_n), 32'h0);
    apb(1'b0, `BPSE_CFG0_OFS, 32'h0);
    chk(rd, `BPSE_CFG_RST);
    apb(1'b0, `BPSE_THR_OFS, 32'h0);
    chk(rd, `BPSE_THR_RST);
    apb(1'b1, `BPSE_THR_OFS, 32'hffff_ffff);
    apb(1'b0, `BPSE_THR_OFS, 32'h0);
    chk(rd, 32'h0000_7f7f);
    apb(1'b1, `BPSE_THR_OFS, 32'h0000_3c32);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], rerr}, 32'h1);
    apb(1'b1, `BPSE_STAT_OFS, 32'hffff_ffff);
    chk(32'(rerr), 32'h1);
    $display("register test done");
    add(cf(1, 0, 0, 8), P1, 6'h00, 1'b1);
    add(cf(1, 0, 0, 9), P1, 6'h00, 1'b0);
    add(cf(1, 3, 0, 8), P1, 6'h00, 1'b0);
    add(cf(1, 1, 0, 8), P1, 6'h00, 1'b1);
    add(cf(1, 1, 0, 7), P1, 6'h00, 1'b0);
    add(cf(1, 1, 1, 4), P1, 6'h00, 1'b1);
    add(cf(1, 1, 1, 3), P1, 6'h00, 1'b0);
    add(cf(1, 2, 0, 8), P1, 6'h00, 1'b1);
    add(cf(1, 2, 0, 9), P1, 6'h00, 1'b0);
    add(cf(1, 0, 1, 5), P1, 6'h00, 1'b0);
    add(cf(1, 2, 1, 4), P1, 6'h00, 1'b1);
    add(cf(2, 0, 0, 24), P1, 6'h00, 1'b1);
    add(cf(2, 0, 0, 25), P1, 6'h00, 1'b0);
    add(cf(2, 1, 0, 23), P1, 6'h00, 1'b0);
    add(cf(2, 1, 0, 24), P1, 6'h00, 1'b1);
    add(cf(2, 2, 0, 24), P1, 6'h00, 1'b1);
    add(cf(2, 2, 1, 20), P1, 6'h00, 1'b1);
    add(cf(2, 0, 1, 21), P1, 6'h00, 1'b0);
    add(cf(3, 2, 0, 4), P1, 6'h00, 1'b1);
    add(cf(3, 2, 2, 4), P1, 6'h00, 1'b1);
    add(cf(3, 0, 2, 5), P1, 6'h00, 1'b0);
    add(cf(3, 2, 0, 5), P2, 6'h00, 1'b1);
    add(cf(3, 2, 0, 2), P2, 6'h00, 1'b0);
    add(cf(4, 2, 0, 10), P2, 6'h00, 1'b1);
    add(cf(4, 0, 0, 11), P2, 6'h00, 1'b0);
    add(cf(4, 1, 0, 10), P2, 6'h00, 1'b1);
    add(cf(5, 2, 0, 22), P2, 6'h00, 1'b1);
    add(cf(5, 1, 0, 21), P2, 6'h00, 1'b0);
    add(cf(5, 0, 0, 22), P2, 6'h00, 1'b1);
    add(cf(4, 0, 4, 0), 32'h0, 6'h00, 1'b0);
    add(cf(3, 1, 0, 31), 32'h0, 6'h00, 1'b0);
    add(cf(3, 1, 2, 31), 32'hf, 6'h00, 1'b0);
    add(cf(1, 0, 4, 9), P1, 6'h00, 1'b1);
    add(cf(1, 0, 4, 8), P1, 6'h00, 1'b0);
    add(cf(0, 0, 0, 0), P1, 6'h3f, 1'b0);
    add(cf(6, 0, 4, 0, 1), P1, 6'h00, 1'b1);
    add(cf(6, 0, 0, 0, 0), P1, 6'h3f, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      add(cf(6, 0, 0, 0, 1 << i), P1, 6'(1 << i), 1'b1);
      add(cf(6, 0, 0, 0, 1 << ((i + 1) % 4)), P1, 6'(1 << i), 1'b0);
    end
    add(cf(6, 0, 0, 0, 16), P1, 6'h10, 1'b1);
    add(cf(6, 0, 0, 0, 16), P1, 6'h00, 1'b0);
    add(cf(6, 0, 0, 0, 32), P1, 6'h20, 1'b1);
    add(cf(6, 0, 0, 0, 32), P1, 6'h10, 1'b0);
    foreach (rows[i])
    begin
      apb(1'b1, `BPSE_CFG0_OFS, rows[i].cfg);
      apb(1'b1, `BPSE_CFG1_OFS, rows[i].cfg);
      scan(rows[i].beams, rows[i].d);
      chk(32'(switching_output_n), {30'h0, {2{rows[i].e}}});
    end
    $display("function table done");
    scan(P1, 6'h00);
    apb(1'b0, `BPSE_STAT_OFS, 32'h0);
    chk(rd, 32'h0318_0800);
    apb(1'b1, `BPSE_CFG0_OFS, cf(1, 0, 0, 8));
    apb(1'b1, `BPSE_CFG1_OFS, cf(1, 0, 0, 8));
    scan(P1, 6'h00);
    edges_was = ctrl_edges;
    beam_blocked <= 32'h0;
    repeat (4) @(posedge pclk);
    #1;
    chk(32'(switching_output_n), 32'h3);
    // the one rise of both outputs is the only edge the control may see
    chk(32'(ctrl_edges), 32'(edges_was) + 32'h1);
    @(posedge pclk);
    scan_done <= 1'b1;
    @(posedge pclk);
    scan_done <= 1'b0;
    #1;
    chk(32'(switching_output_n), 32'h3);
    @(posedge pclk);
    #1;
    chk(32'(switching_output_n), 32'h0);
    // frozen clock enable: neither the scan nor the bus may move
    @(posedge pclk);
    clk_en <= 1'b0;
    scan(P1, 6'h00);
    chk(32'(switching_output_n), 32'h0);
    fork
      apb(1'b0, `BPSE_CFG0_OFS, 32'h0);
      begin
        repeat (4) @(posedge pclk);
        chk(32'(pready), 32'h0);
        clk_en <= 1'b1;
      end
    join
    chk(rd, cf(1, 0, 0, 8));
    $display("scan timing test done");
    // reset in mid-run drops the outputs and the configuration
    scan(P1, 6'h00);
    chk(32'(switching_output_n), 32'h3);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk(32'(switching_output_n), 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `BPSE_CFG0_OFS, 32'h0);
    chk(rd, `BPSE_CFG_RST);
    $display("reset test done");
    finish_test();
  end
endmodule // test_beam_pattern_switch_evaluator
